// [rtl/adrt_result_regs.sv]
/*
  Result registers, mode and channel registers and conversion sequencer
  of a 10-bit successive approximation converter.
  Assumes a single-cycle read or write strobe on the internal memory bus
  and a converter core that presents its approximation on sar_value.
*/
`timescale 1ns/100ps
module adrt_result_regs
  import adrt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Internal memory bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_wide,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_wait,
  output logic bus_ack,
  // Converter core
  input wire logic [9:0] sar_value,
  output logic sample_start,
  output logic conv_active,
  output logic [3:0] chan_sel,
  // Timer triggers
  input wire logic trigger_timer_0,
  input wire logic trigger_timer_1
);

  // Stored registers
  logic [9:0] conversion_result;
  logic [9:0] timer0_sync_result;
  logic [9:0] timer1_sync_result;

  // Configuration registers
  logic [7:0] converter_mode_register;
  logic [7:0] channel_select_register;

  // Sequencer state
  adrt_state_e state;
  adrt_state_e next_state;

  // Start selection
  adrt_start_e target;
  adrt_start_e start_method;
  logic conv_done;

  // Read pipeline
  logic rd_pending;
  logic [15:0] rd_addr;
  logic rd_wide;
  logic [15:0] next_rdata;

  // Mode fields
  wire run = converter_mode_register[ADRT_RUN_BIT];
  wire [2:0] time_sel = converter_mode_register[ADRT_TSEL_LSB +: 3];
  wire [1:0] volt_mode = converter_mode_register[ADRT_VMODE_LSB +: 2];
  wire mode_ok = (volt_mode == ADRT_VMODE_LOW);
  wire [9:0] conv_len = adrt_conv_cycles(time_sel);

  // Start method decode
  assign start_method = adrt_start_e'(channel_select_register[ADRT_TRIG_LSB +: 2]);
  wire start_soft = (start_method == ADRT_START_SOFT);
  wire start_t0 = (start_method == ADRT_START_TMR0) && trigger_timer_0;
  wire start_t1 = (start_method == ADRT_START_TMR1) && trigger_timer_1;
  wire start_req = run && mode_ok && (state == ADRT_IDLE) &&
                   (start_soft || start_t0 || start_t1);

  // Write decode; only mode and channel registers accept writes
  wire wr_byte = bus_wr && !bus_wide;
  wire wr_mode = wr_byte && (bus_addr == ADRT_MODE_ADDR);
  wire wr_chan = wr_byte && (bus_addr == ADRT_CHAN_ADDR);
  wire cfg_write = wr_mode || wr_chan;

  // A config write or a cleared run bit drops the running conversion
  wire abort = (state == ADRT_CONV) && (!run || cfg_write);
  wire capture = (state == ADRT_CONV) && conv_done && !abort;

  // Next sequencer state
  assign next_state = start_req ? ADRT_CONV :
                      (capture || abort) ? ADRT_IDLE : state;

  // Activity flag and read acceptance for the registered outputs
  wire next_active = (next_state == ADRT_CONV);
  wire rd_take = bus_rd && !rd_pending;

  // Read decode on the held address
  wire rd_res16 = rd_wide && (rd_addr == ADRT_RESULT_ADDR);
  wire rd_low8 = !rd_wide && (rd_addr == ADRT_RESULT_ADDR);
  wire rd_hi2 = !rd_wide && (rd_addr == ADRT_RESULT_HI_ADDR);
  wire rd_high8 = !rd_wide && (rd_addr == ADRT_RESULT_H8_ADDR);
  wire rd_t0 = rd_wide && (rd_addr == ADRT_TIMER0_ADDR);
  wire rd_t1 = rd_wide && (rd_addr == ADRT_TIMER1_ADDR);
  wire rd_mode = !rd_wide && (rd_addr == ADRT_MODE_ADDR);
  wire rd_chan = !rd_wide && (rd_addr == ADRT_CHAN_ADDR);

  // Register views as they appear on the bus
  wire [15:0] view_full = {6'h00, conversion_result};
  wire [15:0] view_low = {8'h00, conversion_result[7:0]};
  wire [15:0] view_hi2 = {14'h0000, conversion_result[9:8]};
  wire [15:0] view_high8 = {8'h00, conversion_result[9:2]};
  wire [15:0] view_t0 = {6'h00, timer0_sync_result};
  wire [15:0] view_t1 = {6'h00, timer1_sync_result};
  wire [15:0] view_mode = {8'h00, converter_mode_register};
  wire [15:0] view_chan = {8'h00, channel_select_register & ADRT_CHAN_MASK};

  // Read data select; unmapped addresses read zero
  assign next_rdata =
    rd_res16 ? view_full :
    rd_low8 ? view_low :
    rd_hi2 ? view_hi2 :
    rd_high8 ? view_high8 :
    rd_t0 ? view_t0 :
    rd_t1 ? view_t1 :
    rd_mode ? view_mode :
    rd_chan ? view_chan :
    ADRT_RDATA_RST;

  // Conversion timer
  adrt_conv_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(start_req),
    .abort(abort),
    .len(conv_len),
    .done(conv_done)
  );

  // Mode and channel registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      converter_mode_register <= ADRT_REG8_RST;
      channel_select_register <= ADRT_REG8_RST;
    end else begin
      if (wr_mode) begin
        converter_mode_register <= bus_wdata[7:0];
      end
      if (wr_chan) begin
        channel_select_register <= bus_wdata[7:0] & ADRT_CHAN_MASK;
      end
    end
  end

  // Sequencer, target latch and core strobes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ADRT_IDLE;
      target <= ADRT_START_SOFT;
      sample_start <= 1'b0;
      conv_active <= 1'b0;
      chan_sel <= 4'h0;
    end else begin
      state <= next_state;
      sample_start <= start_req;
      conv_active <= next_active;
      chan_sel <= channel_select_register[ADRT_CHAN_LSB +: 4];
      if (start_req) begin
        target <= start_method;
      end
    end
  end

  // Result capture; bus writes never reach these registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conversion_result <= ADRT_RESULT_RST;
      timer0_sync_result <= ADRT_RESULT_RST;
      timer1_sync_result <= ADRT_RESULT_RST;
    end else if (capture) begin
      unique case (target)
        ADRT_START_TMR0: timer0_sync_result <= sar_value;
        ADRT_START_TMR1: timer1_sync_result <= sar_value;
        default: conversion_result <= sar_value;
      endcase
    end
  end

  // Read with one wait cycle before the data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_pending <= 1'b0;
      rd_addr <= ADRT_RDATA_RST;
      rd_wide <= 1'b0;
      bus_wait <= 1'b0;
      bus_ack <= 1'b0;
      bus_rdata <= ADRT_RDATA_RST;
    end else begin
      bus_ack <= rd_pending;
      if (rd_pending) begin
        rd_pending <= 1'b0;
        bus_wait <= 1'b0;
        bus_rdata <= next_rdata;
      end else if (rd_take) begin
        rd_pending <= 1'b1;
        bus_wait <= 1'b1;
        rd_addr <= bus_addr;
        rd_wide <= bus_wide;
      end
    end
  end

endmodule // adrt_result_regs

// [include/adrt_pkg.sv]
/*
  Shared constants for the converter result and timing register block:
  byte addresses, field positions, reset values, start codes and
  low-voltage conversion lengths.
  Assumes ref_clk is the peripheral hardware clock itself.
*/
package adrt_pkg;

  // Byte addresses on the internal memory bus
  localparam logic [15:0] ADRT_RESULT_ADDR = 16'hff08;
  localparam logic [15:0] ADRT_RESULT_HI_ADDR = 16'hff09;
  localparam logic [15:0] ADRT_RESULT_H8_ADDR = 16'hff1a;
  localparam logic [15:0] ADRT_TIMER0_ADDR = 16'hff16;
  localparam logic [15:0] ADRT_TIMER1_ADDR = 16'hff18;
  localparam logic [15:0] ADRT_MODE_ADDR = 16'hff28;
  localparam logic [15:0] ADRT_CHAN_ADDR = 16'hff0e;

  // Field positions in the mode register
  localparam int ADRT_RUN_BIT = 7;
  localparam int ADRT_TSEL_LSB = 3;
  localparam int ADRT_VMODE_LSB = 1;

  // Field positions in the channel select register
  localparam int ADRT_TRIG_LSB = 4;
  localparam int ADRT_CHAN_LSB = 0;
  localparam logic [7:0] ADRT_CHAN_MASK = 8'h3f;

  // Voltage mode code for low-voltage operation
  localparam logic [1:0] ADRT_VMODE_LOW = 2'h1;

  // Reset values
  localparam logic [9:0] ADRT_RESULT_RST = 10'h000;
  localparam logic [7:0] ADRT_REG8_RST = 8'h00;
  localparam logic [15:0] ADRT_RDATA_RST = 16'h0000;

  // Low-voltage conversion lengths in peripheral clock periods
  localparam logic [9:0] ADRT_CONV_T0 = 10'h210;
  localparam logic [9:0] ADRT_CONV_T1 = 10'h160;
  localparam logic [9:0] ADRT_CONV_T2 = 10'h108;
  localparam logic [9:0] ADRT_CONV_T3 = 10'h0b0;
  localparam logic [9:0] ADRT_CONV_T4 = 10'h084;
  localparam logic [9:0] ADRT_CONV_T5 = 10'h058;
  localparam logic [9:0] ADRT_CONV_T6 = 10'h042;
  localparam logic [9:0] ADRT_CONV_T7 = 10'h02c;
  localparam logic [9:0] ADRT_CNT_ONE = 10'h001;
  localparam logic [9:0] ADRT_CNT_ZERO = 10'h000;

  // Start method codes
  typedef enum logic [1:0] {
    ADRT_START_SOFT = 2'b00,
    ADRT_START_TMR0 = 2'b01,
    ADRT_START_TMR1 = 2'b10,
    ADRT_START_BAD = 2'b11
  } adrt_start_e;

  // Sequencer states
  typedef enum logic {
    ADRT_IDLE = 1'b0,
    ADRT_CONV = 1'b1
  } adrt_state_e;

  // Conversion length for a time-select code
  function automatic logic [9:0] adrt_conv_cycles(input logic [2:0] code);
    logic [9:0] len;
    len = ADRT_CONV_T0;
    unique case (code)
      3'h0: len = ADRT_CONV_T0;
      3'h1: len = ADRT_CONV_T1;
      3'h2: len = ADRT_CONV_T2;
      3'h3: len = ADRT_CONV_T3;
      3'h4: len = ADRT_CONV_T4;
      3'h5: len = ADRT_CONV_T5;
      3'h6: len = ADRT_CONV_T6;
      3'h7: len = ADRT_CONV_T7;
    endcase
    return len;
  endfunction

endpackage

// [rtl/adrt_conv_timer.sv]
/*
  Down counter that times one conversion and pulses done at its end.
  Assumes load and abort come from the sequencer on the same clock.
*/
`timescale 1ns/100ps
module adrt_conv_timer
  import adrt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic abort,
  input wire logic [9:0] len,
  // Status
  output logic done
);

  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic next_done;

  // Reload, stop on abort, else count down to zero
  assign next_cnt = load ? len :
                    (abort || cnt == ADRT_CNT_ZERO) ? ADRT_CNT_ZERO :
                    cnt - ADRT_CNT_ONE;
  assign next_done = (cnt == ADRT_CNT_ONE) && !abort && !load;

  // Counter and end pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= ADRT_CNT_ZERO;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end

endmodule // adrt_conv_timer

// [test/adrt_result_regs_properties.sv]
/* Port checker for the result register block.
   Assumes one clock domain and a bind onto adrt_result_regs. */
`timescale 1ns/100ps
module adrt_result_regs_checker
  import adrt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Memory bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wide,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_wait,
  input wire logic bus_ack,
  // Converter side
  input wire logic sample_start,
  input wire logic conv_active
);
  logic prev_rd;
  wire take = bus_rd && !bus_wait && !prev_rd;
  wire lo_rd = take && bus_addr == ADRT_RESULT_ADDR;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Previous read strobe, to spot a fresh read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_rd <= 1'b0;
    end else begin
      prev_rd <= bus_rd;
    end
  end
  // Read answer steps
  sequence rd_answer;
    bus_wait ##1 (bus_ack && !bus_wait);
  endsequence
  chk_read_wait: assert property (take |=> rd_answer)
    else $error("read answer not wait then ack");
  chk_ack_cause: assert property (bus_ack |-> $past(take, 2))
    else $error("ack without read two cycles before");
  chk_data_hold: assert property ($changed(bus_rdata) |-> bus_ack)
    else $error("read data changed without ack");
  chk_full_zero: assert property (lo_rd && bus_wide |-> ##2 bus_rdata[15:10] == 6'h00)
    else $error("full result upper bits not zero");
  chk_low_byte: assert property (lo_rd && !bus_wide |-> ##2 bus_rdata[15:8] == 8'h00)
    else $error("low byte view too wide");
  chk_high_pair: assert property (take && bus_addr == ADRT_RESULT_HI_ADDR
    |-> ##2 bus_rdata[15:2] == 14'h0000)
    else $error("high byte view too wide");
  chk_timer_zero: assert property (take && (bus_addr == ADRT_TIMER0_ADDR ||
    bus_addr == ADRT_TIMER1_ADDR) |-> ##2 bus_rdata[15:10] == 6'h00)
    else $error("timer result upper bits not zero");
  chk_start_active: assert property (sample_start |-> conv_active)
    else $error("start pulse without active conversion");
  chk_conv_min: assert property ($rose(conv_active) |-> conv_active [*8])
    else $error("conversion shorter than minimum");
endmodule // adrt_result_regs_checker

bind adrt_result_regs adrt_result_regs_checker i_adrt_result_regs_checker (
  .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
  .bus_wide(bus_wide), .bus_rdata(bus_rdata), .bus_wait(bus_wait), .bus_ack(bus_ack),
  .sample_start(sample_start), .conv_active(conv_active));

// [test/adrt_core_model.sv]
/* Converter core stand-in: a fresh random approximation per conversion.
   Assumes the bench seeds the random generator once. */
`timescale 1ns/100ps
module adrt_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Converter handshake
  input wire logic sample_start,
  output logic [9:0] sar_value
);
  // New value on each start, steady through the conversion
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sar_value <= 10'h000;
    end else if (sample_start) begin
      sar_value <= 10'($urandom);
    end
  end
endmodule // adrt_core_model

// [test/tb_adrt_result_regs.sv]
/* Self-checking bench for the result register block.
   Assumes the core model and the bound checker beside it. */
`timescale 1ns/100ps
module tb_adrt_result_regs;
  import adrt_pkg::*;
  logic ref_clk = 0, rst = 1, bus_rd = 0, bus_wr = 0, bus_wide = 0;
  logic trigger_timer_0 = 0, trigger_timer_1 = 0, bus_wait, bus_ack, sample_start, conv_active;
  logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata;
  logic [9:0] sar_value, ex;
  logic [3:0] chan_sel, ch;
  int n_fail = 0, compares = 0, n;
  always #50 ref_clk = ~ref_clk;
  adrt_result_regs i_adrt_result_regs (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wide(bus_wide), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_wait(bus_wait), .bus_ack(bus_ack), .sar_value(sar_value),
    .sample_start(sample_start), .conv_active(conv_active), .chan_sel(chan_sel),
    .trigger_timer_0(trigger_timer_0), .trigger_timer_1(trigger_timer_1));
  adrt_core_model i_adrt_core_model (.ref_clk(ref_clk), .rst(rst),
    .sample_start(sample_start), .sar_value(sar_value));
  // Compare and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bus cycles
  task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e);
    @(posedge ref_clk) #10;
    bus_addr = a;
    bus_wide = w;
    bus_rd = 1;
    @(posedge ref_clk) #10;
    bus_rd = 0;
    @(posedge ref_clk) #10;
    chk({15'h0000, bus_ack}, 16'h0001);
    chk(bus_rdata, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge ref_clk) #10;
    bus_addr = a;
    bus_wdata = v;
    bus_wide = 0;
    bus_wr = 1;
    @(posedge ref_clk) #10;
    bus_wr = 0;
  endtask
  task automatic wait_for(input logic v);
    n = 0;
    while (conv_active !== v && n < 600) begin
      n++;
      @(posedge ref_clk) #10;
    end
    if (conv_active !== v) n_fail++;
  endtask
  // Expected values
  function automatic logic [15:0] md(input logic r, input int t);
    return {8'h00, r, 1'b0, 3'(t), ADRT_VMODE_LOW, 1'b0};
  endfunction
  function automatic int clen(input int t);
    int tab[8] = '{528, 352, 264, 176, 132, 88, 66, 44};
    return tab[t];
  endfunction
  // Main sequence
  initial begin
    void'($urandom(32'h68bca022));
    repeat (3) @(posedge ref_clk);
    #10 rst = 0;
    rd(ADRT_RESULT_ADDR, 1, 16'h0000);
    rd(ADRT_RESULT_H8_ADDR, 0, 16'h0000);
    rd(ADRT_TIMER0_ADDR, 1, 16'h0000);
    rd(ADRT_TIMER1_ADDR, 1, 16'h0000);
    for (int t = 0; t < 8; t++) begin
      ch = 4'($urandom % 9);
      wr(ADRT_CHAN_ADDR, (16'(t % 2 + 1) << ADRT_TRIG_LSB) | 16'(ch));
      wr(ADRT_MODE_ADDR, md(0, t));
      wr(ADRT_MODE_ADDR, md(1, t));
      chk({12'h000, chan_sel}, {12'h000, ch});
      rd(ADRT_CHAN_ADDR, 0, {10'h000, 2'(t % 2 + 1), ch});
      @(posedge ref_clk) #10;
      if (t % 2) trigger_timer_1 = 1;
      else trigger_timer_0 = 1;
      @(posedge ref_clk) #10;
      trigger_timer_0 = 0;
      trigger_timer_1 = 0;
      chk({15'h0000, sample_start}, 16'h0001);
      wait_for(0);
      chk(16'(n), 16'(clen(t) + 1));
      ex = sar_value;
      rd(t % 2 ? ADRT_TIMER1_ADDR : ADRT_TIMER0_ADDR, 1, {6'h00, ex});
      rd(ADRT_RESULT_ADDR, 1, 16'h0000);
      wr(ADRT_MODE_ADDR, md(0, t));
    end
    wr(ADRT_CHAN_ADDR, 16'h0000);
    wr(ADRT_MODE_ADDR, md(1, 7));
    wait_for(1);
    wait_for(0);
    ex = sar_value;
    wr(ADRT_RESULT_ADDR, 16'h03ff);
    rd(ADRT_RESULT_ADDR, 1, {6'h00, ex});
    rd(ADRT_RESULT_ADDR, 0, {8'h00, ex[7:0]});
    rd(ADRT_RESULT_HI_ADDR, 0, {14'h0000, ex[9:8]});
    rd(ADRT_RESULT_H8_ADDR, 0, {8'h00, ex[9:2]});
    rd(16'hff00, 1, 16'h0000);
    wr(ADRT_MODE_ADDR, md(0, 7));
    rd(ADRT_RESULT_ADDR, 1, {6'h00, ex});
    wr(ADRT_CHAN_ADDR, 16'h0030);
    wr(ADRT_MODE_ADDR, md(1, 7));
    trigger_timer_0 = 1;
    trigger_timer_1 = 1;
    repeat (20) @(posedge ref_clk) #10;
    chk({15'h0000, conv_active}, 16'h0000);
    trigger_timer_0 = 0;
    trigger_timer_1 = 0;
    wr(ADRT_MODE_ADDR, md(0, 7));
    wr(ADRT_CHAN_ADDR, 16'h0000);
    wr(ADRT_MODE_ADDR, 16'h00b8);
    repeat (20) @(posedge ref_clk) #10;
    chk({15'h0000, conv_active}, 16'h0000);
    @(posedge ref_clk) #10;
    rst = 1;
    @(posedge ref_clk) #10;
    rst = 0;
    rd(ADRT_RESULT_ADDR, 1, 16'h0000);
    rd(ADRT_RESULT_ADDR, 0, 16'h0000);
    rd(ADRT_TIMER0_ADDR, 1, 16'h0000);
    rd(ADRT_TIMER1_ADDR, 1, 16'h0000);
    print_verdict();
  end
  // Watchdog
  initial begin
    #1_000_000;
    n_fail++;
    print_verdict();
  end
endmodule // tb_adrt_result_regs
